//--- logic/audio_receiver_control_regs.sv
// i2c register bank of a dual-channel audio receiver
// Function
// - status pair refreshes only while sensing enabled
// - odd status bits show above upper threshold
// - even status bits show above lower threshold
// - audio presence sets flag, pulls interrupt
// - clip warning sets flag, pulls interrupt
// - jack flag shows state, change pulls interrupt
// - overheat sets flag, pulls interrupt
// - event register read releases interrupt, clears flags
// - audio interrupt enable clears when it fires
// - clip interrupt enable clears when it fires
// - jack interrupt enable clears when it fires
// - zero-cross bit defers gain to crossing
// - control bit 1 selects mute
// - control bit 0 selects power down
// - select bits form slave address bits 2,1
// - address changes only while interrupt held low
// - interrupt output is active-low open drain
// - code 1110 senses only, 0000 disables port
// - burst read continues until master not-acknowledge
`timescale 1ns/100ps
`default_nettype none
module audio_receiver_control_regs #(
  parameter logic [2:0] DIE_CODE = audio_rx_pkg::DIE_CODE_DEFAULT
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic int_in,
  output logic int_out,
  output logic int_oe,
  input wire audio_rx_pkg::sense_in_s sense_in,
  output var audio_rx_pkg::ctrl_out_s ctrl_out
);
  import audio_rx_pkg::*;

  // synchronised pins
  logic scl_s, sda_s, int_s;
  sense_in_s sense_s;
  // previous samples for edge finding
  logic scl_d_reg, sda_d_reg;
  sense_in_s sense_d_reg;
  // bus engine state
  slave_state_e state_reg, ack_next_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shift_reg;
  logic [2:0] ptr_reg;
  logic sda_oe_reg, nack_reg, held_low_reg;
  // register contents
  logic [7:0] status_reg, ctrl_reg, gain_reg, gain_applied_reg;
  logic [1:0] addr_sel_reg;
  logic [15:0] port_cfg_reg;
  logic [3:0] flags_reg;
  logic int_pending_reg, gain_pending_reg;
  logic [3:0] sense_en_reg, src_en_reg, diode_reg;
  // decoded events and strobes
  logic start_cond, stop_cond, scl_rise, scl_fall;
  logic audio_rise, clip_rise, heat_rise, jack_change, zc_rise;
  logic reg_wr, rd_load, evt_clear, irq_set, addr_hit;
  logic [2:0] rd_addr;
  logic [7:0] rd_byte;

  // every serial, interrupt and sense pin passes two flops first; rst_n and clk_en do not
  sync_two_stage #(
    .WIDTH($bits(sense_in_s) + 3)
  ) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .async_in({scl_in, sda_in, int_in, sense_in}),
    .sync_out({scl_s, sda_s, int_s, sense_s})
  );

  // delayed copies for edge detection
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      sense_d_reg <= '0;
    end else if (clk_en) begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      sense_d_reg <= sense_s;
    end
  end

  // bus conditions: start/stop are sda edges with scl high
  assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_cond = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  // analog events
  assign audio_rise = sense_s.audio_present & ~sense_d_reg.audio_present;
  assign clip_rise = sense_s.clip & ~sense_d_reg.clip;
  assign heat_rise = sense_s.overheat & ~sense_d_reg.overheat;
  assign jack_change = sense_s.jack_inserted ^ sense_d_reg.jack_inserted;
  assign zc_rise = sense_s.zero_cross & ~sense_d_reg.zero_cross;

  // own address: fixed prefix over the two select bits
  assign addr_hit = (shift_reg[7:1] == {SLAVE_ADDR_PREFIX, addr_sel_reg});
  // write strobe at the fall closing a data byte
  assign reg_wr = scl_fall && state_reg == S_WDATA && cnt_reg == BYTE_BITS;
  // next read byte is fetched when the previous ack ends
  assign rd_load = scl_fall && ((state_reg == S_ACK && ack_next_reg == S_RDATA)
                   || (state_reg == S_RACK && !nack_reg));
  assign rd_addr = (state_reg == S_RACK) ? ptr_reg + 3'h1 : ptr_reg;
  assign evt_clear = rd_load && rd_addr == REG_EVENTS;

  // read multiplexer; unmapped pointer reads zero
  always_comb begin
    case (rd_addr)
      REG_DIAG_STATUS: rd_byte = status_reg;
      REG_EVENTS: rd_byte = {flags_reg, 1'b0, DIE_CODE};
      REG_MAIN_CTRL: rd_byte = ctrl_reg;
      REG_ADDR_SEL: rd_byte = {6'h00, addr_sel_reg};
      REG_PORT_LO: rd_byte = port_cfg_reg[7:0];
      REG_PORT_HI: rd_byte = port_cfg_reg[15:8];
      REG_GAIN: rd_byte = gain_reg;
      default: rd_byte = 8'h00;
    endcase
  end

  // i2c slave engine, sda only changes while scl is low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      ack_next_reg <= S_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 3'h0;
      sda_oe_reg <= 1'b0;
      nack_reg <= 1'b1;
    end else if (clk_en) begin
      if (start_cond) begin
        // start or repeated start always restarts
        state_reg <= S_ADDR;
        cnt_reg <= 4'h0;
        sda_oe_reg <= 1'b0;
      end else if (stop_cond) begin
        state_reg <= S_IDLE;
        sda_oe_reg <= 1'b0;
      end else if (scl_rise) begin
        case (state_reg)
          S_ADDR, S_REG, S_WDATA: begin
            // msb first
            shift_reg <= {shift_reg[6:0], sda_s};
            cnt_reg <= cnt_reg + 4'h1;
          end
          S_RACK: nack_reg <= sda_s;
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state_reg)
          S_ADDR: if (cnt_reg == BYTE_BITS) begin
            if (addr_hit) begin
              sda_oe_reg <= 1'b1;
              ack_next_reg <= shift_reg[0] ? S_RDATA : S_REG;
              state_reg <= S_ACK;
            end else begin
              // foreign address: ignore until next start
              state_reg <= S_IDLE;
            end
          end
          S_REG: if (cnt_reg == BYTE_BITS) begin
            ptr_reg <= shift_reg[2:0];
            sda_oe_reg <= 1'b1;
            ack_next_reg <= S_WDATA;
            state_reg <= S_ACK;
          end
          S_WDATA: if (cnt_reg == BYTE_BITS) begin
            ptr_reg <= ptr_reg + 3'h1;
            sda_oe_reg <= 1'b1;
            ack_next_reg <= S_WDATA;
            state_reg <= S_ACK;
          end
          S_ACK: begin
            state_reg <= ack_next_reg;
            if (ack_next_reg == S_RDATA) begin
              // first bit goes out on this fall
              shift_reg <= {rd_byte[6:0], 1'b0};
              sda_oe_reg <= ~rd_byte[7];
              cnt_reg <= 4'h1;
            end else begin
              sda_oe_reg <= 1'b0;
              cnt_reg <= 4'h0;
            end
          end
          S_RDATA: begin
            if (cnt_reg == BYTE_BITS) begin
              // free sda for the master's ack bit
              sda_oe_reg <= 1'b0;
              state_reg <= S_RACK;
            end else begin
              sda_oe_reg <= ~shift_reg[7];
              shift_reg <= {shift_reg[6:0], 1'b0};
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
          S_RACK: begin
            ptr_reg <= ptr_reg + 3'h1;
            if (nack_reg) begin
              state_reg <= S_IDLE;
            end else begin
              shift_reg <= {rd_byte[6:0], 1'b0};
              sda_oe_reg <= ~rd_byte[7];
              cnt_reg <= 4'h1;
              state_reg <= S_RDATA;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // tracks that the interrupt wire is pulled low by someone else
  // since the start; our own pull-down does not count
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      held_low_reg <= 1'b0;
    end else if (clk_en) begin
      if (start_cond) begin
        held_low_reg <= ~int_s & ~int_pending_reg;
      end else if (int_s || int_pending_reg) begin
        held_low_reg <= 1'b0;
      end
    end
  end

  // slave address select, guarded by the external pull-down
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addr_sel_reg <= RESET_VALUE[1:0];
    end else if (clk_en) begin
      if (reg_wr && ptr_reg == REG_ADDR_SEL && held_low_reg && !int_s) begin
        addr_sel_reg <= shift_reg[1:0] & ADDR_SEL_MASK[1:0];
      end
    end
  end

  // main control; enables clear themselves when their interrupt fires,
  // the self-clear is placed last so it beats a same-cycle write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= RESET_VALUE;
    end else if (clk_en) begin
      if (reg_wr && ptr_reg == REG_MAIN_CTRL) begin
        ctrl_reg <= shift_reg & MAIN_CTRL_MASK;
      end
      if (audio_rise && ctrl_reg[BIT_AUDIO_IRQ_EN]) begin
        ctrl_reg[BIT_AUDIO_IRQ_EN] <= 1'b0;
      end
      if (clip_rise && ctrl_reg[BIT_CLIP_IRQ_EN]) begin
        ctrl_reg[BIT_CLIP_IRQ_EN] <= 1'b0;
      end
      if (jack_change && ctrl_reg[BIT_JACK_IRQ_EN]) begin
        ctrl_reg[BIT_JACK_IRQ_EN] <= 1'b0;
      end
    end
  end

  // port configuration and gain registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port_cfg_reg <= {RESET_VALUE, RESET_VALUE};
      gain_reg <= RESET_VALUE;
    end else if (clk_en && reg_wr) begin
      case (ptr_reg)
        REG_PORT_LO: port_cfg_reg[7:0] <= shift_reg;
        REG_PORT_HI: port_cfg_reg[15:8] <= shift_reg;
        REG_GAIN: gain_reg <= shift_reg;
        default: ;
      endcase
    end
  end

  // gain reaching the amplifier: direct, or held to a zero crossing
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gain_applied_reg <= RESET_VALUE;
      gain_pending_reg <= 1'b0;
    end else if (clk_en) begin
      if (reg_wr && ptr_reg == REG_GAIN) begin
        if (ctrl_reg[BIT_ZERO_CROSS]) begin
          gain_pending_reg <= 1'b1;
        end else begin
          gain_applied_reg <= shift_reg;
          gain_pending_reg <= 1'b0;
        end
      end else if (gain_pending_reg && (zc_rise || !ctrl_reg[BIT_ZERO_CROSS])) begin
        // dropping the zero-cross bit releases a waiting gain
        gain_applied_reg <= gain_reg;
        gain_pending_reg <= 1'b0;
      end
    end
  end

  // event flags: set beats the read clear in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= 4'h0;
    end else if (clk_en) begin
      flags_reg[FLAG_AUDIO] <= audio_rise | (flags_reg[FLAG_AUDIO] & ~evt_clear);
      flags_reg[FLAG_CLIP] <= clip_rise | (flags_reg[FLAG_CLIP] & ~evt_clear);
      flags_reg[FLAG_HEAT] <= heat_rise | (flags_reg[FLAG_HEAT] & ~evt_clear);
      if (jack_change) begin
        flags_reg[FLAG_JACK] <= sense_s.jack_inserted;
      end else if (evt_clear) begin
        flags_reg[FLAG_JACK] <= 1'b0;
      end
    end
  end

  // interrupt request; overheat has no enable
  assign irq_set = (audio_rise & ctrl_reg[BIT_AUDIO_IRQ_EN])
                 | (clip_rise & ctrl_reg[BIT_CLIP_IRQ_EN])
                 | (jack_change & ctrl_reg[BIT_JACK_IRQ_EN])
                 | heat_rise;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      int_pending_reg <= 1'b0;
    end else if (clk_en) begin
      int_pending_reg <= irq_set | (int_pending_reg & ~evt_clear);
    end
  end

  // per-port diagnostic decode and comparator capture
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      logic [3:0] code;
      logic sense_w;
      assign code = port_cfg_reg[4*p +: 4];
      // sensing on for every code but off and diode
      assign sense_w = (code != PORT_OFF) && (code != PORT_DIODE);
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          status_reg[2*p +: 2] <= 2'h0;
          sense_en_reg[p] <= 1'b0;
          src_en_reg[p] <= 1'b0;
          diode_reg[p] <= 1'b0;
        end else if (clk_en) begin
          sense_en_reg[p] <= sense_w;
          src_en_reg[p] <= sense_w && code != PORT_SENSE_ONLY;
          diode_reg[p] <= code == PORT_DIODE;
          if (code == PORT_OFF) begin
            // disabled port reads as both low
            status_reg[2*p +: 2] <= 2'h0;
          end else if (sense_w) begin
            status_reg[2*p+1] <= sense_s.cmp_upper[p];
            status_reg[2*p] <= sense_s.cmp_lower[p];
          end
        end
      end
    end
  endgenerate

  // open-drain pins: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_reg;
  assign int_out = 1'b0;
  assign int_oe = int_pending_reg;

  // controls to the analog side, all from flops
  assign ctrl_out.mute = ctrl_reg[BIT_MUTE];
  assign ctrl_out.power_down = ctrl_reg[BIT_POWER_DOWN];
  assign ctrl_out.gain_left = gain_applied_reg[7:4];
  assign ctrl_out.gain_right = gain_applied_reg[3:0];
  assign ctrl_out.port_cfg = port_cfg_reg;
  assign ctrl_out.sense_en = sense_en_reg;
  assign ctrl_out.current_src_en = src_en_reg;
  assign ctrl_out.diode_en = diode_reg;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  status_hold_a: assert property (clk_en && port_cfg_reg[3:0] == PORT_DIODE |=> $stable(status_reg[1:0])) else $error("status moved while sensing off");
  upper_track_a: assert property (clk_en && port_cfg_reg[3:0] == PORT_SENSE_ONLY |=> status_reg[1] == $past(sense_s.cmp_upper[0])) else $error("upper flag not tracking");
  lower_track_a: assert property (clk_en && port_cfg_reg[7:4] != PORT_OFF && port_cfg_reg[7:4] != PORT_DIODE |=> status_reg[2] == $past(sense_s.cmp_lower[1])) else $error("lower flag not tracking");
  audio_evt_a: assert property (clk_en && audio_rise && ctrl_reg[BIT_AUDIO_IRQ_EN] |=> flags_reg[FLAG_AUDIO] && int_oe && !ctrl_reg[BIT_AUDIO_IRQ_EN]) else $error("audio event lost");
  clip_evt_a: assert property (clk_en && clip_rise && ctrl_reg[BIT_CLIP_IRQ_EN] |=> flags_reg[FLAG_CLIP] && int_oe && !ctrl_reg[BIT_CLIP_IRQ_EN]) else $error("clip event lost");
  jack_evt_a: assert property (clk_en && jack_change && ctrl_reg[BIT_JACK_IRQ_EN] |=> int_oe && !ctrl_reg[BIT_JACK_IRQ_EN] && flags_reg[FLAG_JACK] == $past(sense_s.jack_inserted)) else $error("jack event lost");
  heat_evt_a: assert property (clk_en && heat_rise |=> flags_reg[FLAG_HEAT] && int_oe) else $error("overheat not flagged");
  read_clear_a: assert property (clk_en && evt_clear && !irq_set && !audio_rise && !clip_rise && !heat_rise && !jack_change |=> !int_oe && flags_reg == 4'h0) else $error("event read did not clear");
  gain_direct_a: assert property (clk_en && reg_wr && ptr_reg == REG_GAIN && !ctrl_reg[BIT_ZERO_CROSS] |=> gain_applied_reg == $past(shift_reg)) else $error("gain not applied directly");
  gain_wait_a: assert property (gain_pending_reg && ctrl_reg[BIT_ZERO_CROSS] && !zc_rise && !reg_wr |=> $stable(gain_applied_reg)) else $error("gain applied before crossing");
  ctrl_write_a: assert property (clk_en && reg_wr && ptr_reg == REG_MAIN_CTRL |=> ctrl_out.mute == $past(shift_reg[BIT_MUTE]) && ctrl_out.power_down == $past(shift_reg[BIT_POWER_DOWN])) else $error("mute or power down wrong");
  addr_guard_a: assert property (reg_wr && ptr_reg == REG_ADDR_SEL && !held_low_reg |=> $stable(addr_sel_reg)) else $error("address changed unguarded");
  ptr_step_a: assert property (clk_en && reg_wr |=> ptr_reg == $past(ptr_reg) + 3'h1) else $error("pointer did not step");
  nack_end_a: assert property (clk_en && scl_fall && state_reg == S_RACK && nack_reg |=> state_reg == S_IDLE && !sda_oe) else $error("read did not end on nack");

  read_events_c: cover property (evt_clear && int_oe);
  zero_cross_c: cover property (gain_pending_reg ##[1:1000] !gain_pending_reg);
  burst_read_c: cover property (rd_load ##[1:1000] rd_load);
  addr_change_c: cover property (clk_en && reg_wr && ptr_reg == REG_ADDR_SEL && held_low_reg && !int_s);
endmodule // audio_receiver_control_regs
`default_nettype wire

//--- pkg/audio_rx_pkg.sv
// constants, carrier structs and state enum for the audio receiver registers
package audio_rx_pkg;
  // number of diagnostic ports and i2c byte length
  localparam int NUM_PORTS = 4;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // register pointers
  localparam logic [2:0] REG_DIAG_STATUS = 3'h0;
  localparam logic [2:0] REG_EVENTS = 3'h1;
  localparam logic [2:0] REG_MAIN_CTRL = 3'h2;
  localparam logic [2:0] REG_ADDR_SEL = 3'h3;
  localparam logic [2:0] REG_PORT_LO = 3'h4;
  localparam logic [2:0] REG_PORT_HI = 3'h5;
  localparam logic [2:0] REG_GAIN = 3'h6;
  // reset value of every writable register
  localparam logic [7:0] RESET_VALUE = 8'h00;
  // writable bits of the two control registers
  localparam logic [7:0] MAIN_CTRL_MASK = 8'he7;
  localparam logic [7:0] ADDR_SEL_MASK = 8'h03;
  // main control bit positions
  localparam int BIT_AUDIO_IRQ_EN = 7;
  localparam int BIT_CLIP_IRQ_EN = 6;
  localparam int BIT_JACK_IRQ_EN = 5;
  localparam int BIT_ZERO_CROSS = 2;
  localparam int BIT_MUTE = 1;
  localparam int BIT_POWER_DOWN = 0;
  // event flag positions inside the 4-bit flag field (bits 7..4)
  localparam int FLAG_AUDIO = 3;
  localparam int FLAG_CLIP = 2;
  localparam int FLAG_JACK = 1;
  localparam int FLAG_HEAT = 0;
  // fixed upper slave address pattern
  localparam logic [4:0] SLAVE_ADDR_PREFIX = 5'h1a;
  // port configuration codes
  localparam logic [3:0] PORT_OFF = 4'h0;
  localparam logic [3:0] PORT_SENSE_ONLY = 4'he;
  localparam logic [3:0] PORT_DIODE = 4'hf;
  // die code default, value arbitrary
  localparam logic [2:0] DIE_CODE_DEFAULT = 3'h6;

  // analog side inputs, asynchronous to clock
  typedef struct packed {
    logic [3:0] cmp_upper;
    logic [3:0] cmp_lower;
    logic audio_present;
    logic clip;
    logic jack_inserted;
    logic overheat;
    logic zero_cross;
  } sense_in_s;

  // controls toward the analog side
  typedef struct packed {
    logic mute;
    logic power_down;
    logic [3:0] gain_left;
    logic [3:0] gain_right;
    logic [15:0] port_cfg;
    logic [3:0] sense_en;
    logic [3:0] current_src_en;
    logic [3:0] diode_en;
  } ctrl_out_s;

  // i2c slave states
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_REG, S_WDATA, S_ACK, S_RDATA, S_RACK
  } slave_state_e;
endpackage

//--- logic/sync_two_stage.sv
// two flip-flop synchroniser, one stage pair per bit
`timescale 1ns/100ps
`default_nettype none
module sync_two_stage #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output var logic [WIDTH-1:0] sync_out
);
  // first stage is read only by the second
  logic [WIDTH-1:0] meta_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // both stages reset low, frozen with the enable
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          meta_reg[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else if (clk_en) begin
          meta_reg[i] <= async_in[i];
          sync_out[i] <= meta_reg[i];
        end
      end
    end
  endgenerate
endmodule // sync_two_stage
`default_nettype wire

//--- bench/i2c_host_model.sv
// i2c bus master model that drives the register bank's serial pins
`timescale 1ns/100ps
`default_nettype none
module i2c_host_model (
  input wire logic clock,
  input wire logic sda_line,
  output var logic scl_o,
  output var logic sda_pull,
  output var logic rd_valid,
  output var logic [7:0] rd_data
);
  logic ack; // address acknowledge of the latest frame
  initial {scl_o, sda_pull, rd_valid, rd_data} = {1'b1, 1'b0, 1'b0, 8'h00};
  task automatic hold(input int n);
    repeat (n) @(negedge clock);
  endtask
  // host-side reading of one port's status pair
  // 0 no fault, 1 ground short or off, 2 battery, 3 open, 7 invalid
  function automatic logic [2:0] fault(input logic [1:0] pair,
                                       input logic [3:0] code);
    case (pair)
      2'b00: fault = 3'h1;
      2'b01: fault = 3'h0;
      2'b10: fault = 3'h7;
      default: fault = (code == 4'he) ? 3'h2 : 3'h3;
    endcase
  endfunction
  // sda moves one clock after scl falls; long low phase lets the
  // slave's late release of its ack settle before scl rises again
  task automatic bit_io(input logic b, output logic s);
    hold(1);
    sda_pull = ~b;
    hold(4);
    scl_o = 1'b1;
    hold(3);
    s = sda_line;
    scl_o = 1'b0;
  endtask
  // start or repeated start (is_stop low), stop otherwise
  task automatic cond(input logic is_stop);
    hold(1);
    sda_pull = is_stop;
    hold(4);
    scl_o = 1'b1;
    hold(3);
    sda_pull = ~is_stop;
    hold(4);
    scl_o = is_stop; // serial clock stands high between frames
  endtask
  // one byte out msb first, then the ninth bit
  task automatic xfer(input logic [7:0] d, input logic last,
                      output logic [7:0] q, output logic a);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
      q[i] = s;
    end
    bit_io(last, s);
    a = ~s;
  endtask
  // single register write: start, address, pointer, data, stop
  task automatic wr(input logic [7:0] dev, input logic [7:0] rg,
                    input logic [7:0] v);
    logic [7:0] q;
    logic a;
    cond(1'b0);
    xfer(dev, 1'b1, q, ack);
    xfer(rg, 1'b1, q, a);
    xfer(v, 1'b1, q, a);
    cond(1'b1);
  endtask
  // burst read, not-acknowledge on the final byte only
  task automatic rd(input logic [7:0] dev, input logic [7:0] rg,
                    input int n);
    logic [7:0] q;
    logic a;
    cond(1'b0);
    xfer(dev, 1'b1, q, ack);
    xfer(rg, 1'b1, q, a);
    cond(1'b0);
    xfer(dev | 8'h01, 1'b1, q, a);
    for (int i = 0; i < n; i++) begin
      xfer(8'hff, i == n - 1, q, a);
      rd_data = q;
      rd_valid = 1'b1;
      hold(1);
      rd_valid = 1'b0;
    end
    cond(1'b1);
  endtask
endmodule // i2c_host_model
`default_nettype wire

//--- bench/audio_receiver_control_regs_tb_top.sv
// testbench for the audio receiver register bank
`timescale 1ns/100ps
`default_nettype none
module audio_receiver_control_regs_tb_top;
  import audio_rx_pkg::*;
  localparam logic [2:0] DIE = 3'h5; // die code, value arbitrary
  logic clock, rst_n, ext_pull, sda_out, int_out, sda_oe, int_oe;
  logic scl, sda_pull, rd_valid, sda_line, int_line;
  logic [7:0] rd_data, q [$]; // q holds expected read bytes
  int bad_count = 0, samples_checked = 0, cycles = 0, seed = 37865;
  sense_in_s sense;
  ctrl_out_s ctrl;
  // both wires have pull-ups; anyone may pull low
  assign sda_line = ~(sda_pull | sda_oe);
  assign int_line = ~(int_oe | ext_pull);
  audio_receiver_control_regs #(.DIE_CODE(DIE)) dut (.clock(clock),
    .rst_n(rst_n), .clk_en(1'b1), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .int_in(int_line),
    .int_out(int_out), .int_oe(int_oe), .sense_in(sense), .ctrl_out(ctrl));
  i2c_host_model host (.clock(clock), .sda_line(sda_line), .scl_o(scl),
    .sda_pull(sda_pull), .rd_valid(rd_valid), .rd_data(rd_data));
  task automatic check8(input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // oldest expectation against each byte the host reads back
  always @(posedge clock)
    if (rd_valid === 1'b1) check8(q.pop_front(), rd_data);
  // hang guard, well above the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    logic [7:0] g, p;
    {rst_n, ext_pull, sense} = '0;
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    repeat (6) @(negedge clock);
    // reset values, die code, pointer running past the map
    for (int i = 0; i < 8; i++) q.push_back(i == 1 ? {5'h00, DIE} : 8'h00);
    host.rd(8'hd0, 8'h00, 8);
    for (int v = 1; v < 3; v++) begin
      host.wr(8'hd0, 8'h02, 8'(v));
      check8(8'(v), {6'h00, ctrl.mute, ctrl.power_down});
    end
    g = 8'($random(seed));
    host.wr(8'hd0, 8'h06, g);
    check8(g, {ctrl.gain_left, ctrl.gain_right});
    host.wr(8'hd0, 8'h02, 8'h04);
    p = ~g;
    host.wr(8'hd0, 8'h06, p);
    check8(g, {ctrl.gain_left, ctrl.gain_right});
    sense.zero_cross = 1'b1;
    repeat (6) @(negedge clock);
    check8(p, {ctrl.gain_left, ctrl.gain_right});
    // port 1 sources current, port 0 senses only, ports 2 and 3 off
    host.wr(8'hd0, 8'h04, 8'h2e);
    {sense.cmp_upper, sense.cmp_lower} = 8'($random(seed));
    repeat (4) @(negedge clock);
    q.push_back({4'h0, sense.cmp_upper[1], sense.cmp_lower[1],
                 sense.cmp_upper[0], sense.cmp_lower[0]});
    host.rd(8'hd0, 8'h00, 1);
    // port 0 both high with source off, port 1 inside the window
    sense.cmp_upper = 4'h1;
    sense.cmp_lower = 4'h3;
    host.wr(8'hd0, 8'h04, 8'h2f);
    check8(8'h22, {ctrl.sense_en, ctrl.current_src_en});
    check8(8'h1f, {ctrl.diode_en, ctrl.port_cfg[3:0]});
    check8(8'h00, {6'h00, sda_out, int_out});
    // port 0 now holds its diode state, so its old pair must stay
    {sense.cmp_upper, sense.cmp_lower} = 8'h02;
    repeat (4) @(negedge clock);
    q.push_back(8'h07);
    host.rd(8'hd0, 8'h00, 1);
    check8(8'h02, {5'h00, host.fault(rd_data[1:0], 4'he)});
    check8(8'h00, {5'h00, host.fault(rd_data[3:2], 4'h2)});
    // each event in turn: audio, clip, jack, heat
    host.wr(8'hd0, 8'h02, 8'he0);
    for (int k = 0; k < 4; k++) begin
      sense[4-k] = 1'b1;
      repeat (6) @(negedge clock);
      check8(8'h01, {7'h00, int_oe});
      if (k != 2) sense[4-k] = 1'b0;
      q.push_back({4'h8 >> k, 1'b0, DIE});
      host.rd(8'hd0, 8'h01, 1);
      check8(8'h00, {7'h00, int_oe});
    end
    // enables cleared themselves, so this event stays masked
    sense.audio_present = 1'b1;
    repeat (6) @(negedge clock);
    check8(8'h00, {7'h00, int_oe});
    q.push_back({4'h8, 1'b0, DIE});
    q.push_back(8'h00);
    host.rd(8'hd0, 8'h01, 2);
    // address select refused without the wire held, taken with it
    host.wr(8'hd0, 8'h03, 8'h02);
    q.push_back(8'h00);
    host.rd(8'hd0, 8'h03, 1);
    ext_pull = 1'b1;
    host.wr(8'hd0, 8'h03, 8'h02);
    ext_pull = 1'b0;
    host.wr(8'hd0, 8'h02, 8'h00);
    check8(8'h00, {7'h00, host.ack});
    q.push_back(8'h02);
    host.rd(8'hd4, 8'h03, 1);
    give_verdict();
  end
endmodule // audio_receiver_control_regs_tb_top
`default_nettype wire
